// >>> core/ctd_top.sv
`timescale 1ns/10ps
// Behaviour
// - Fault: disabled outputs float, enabled driven.
// - Fault value bits give overridden output levels.
// - Debug bits survive software reset only.
// - Break with enable raises fault, sets flag.
// - Run bit zero halts timer in debug.
// - Channel match emits event when enabled.
// - Channel input events accepted only when enabled.
// - Counter event inputs act only when enabled.
// - Invert bit inverts counter event source.
// - Cycle event emitted at selected point.
// - Retrigger event emitted when enabled.
// - Wrap event emitted at top or zero.
// - Cycle select: begin, end, between, boundary.
// - Input one codes off and retrigger.
// - Input one codes two to seven apply.
// - Input zero codes zero to seven apply.
// - Event control writable only while disabled, unguarded.
module ctd_top
    import ctd_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 srst,
    input  wire ctd_bus_req_t         bus_req,
    output logic      [31:0]          bus_rdata,
    input  wire logic                 write_guard,
    input  wire logic                 dbg_halt,
    input  wire logic                 dbg_break,
    input  wire ctd_core_ev_t         core_ev,
    input  wire logic [CTD_CH_N-1:0]  ch_ev_in,
    input  wire logic                 cnt_ev_in0,
    input  wire logic                 cnt_ev_in1,
    input  wire logic [CTD_OUT_N-1:0] wave_in,
    output logic      [CTD_OUT_N-1:0] wave_out,
    output logic      [CTD_OUT_N-1:0] wave_oe_n,
    output logic                      timer_run,
    output logic                      fault_active,
    output logic      [CTD_CH_N-1:0]  ch_ev_accept,
    output logic      [CTD_CH_N-1:0]  ch_ev_out,
    output logic                      cyc_ev_out,
    output logic                      trg_ev_out,
    output logic                      wrap_ev_out,
    output logic      [CTD_ACT_N-1:0] act0_pulse,
    output logic      [CTD_ACT_N-1:0] act1_pulse,
    output logic                      irq
);

    // Byte address of a register index.
    function automatic logic [7:0] baddr(input logic [7:0] idx);
        baddr = {idx[5:0], 2'b00};
    endfunction

    // Sticky bit update where a hardware set wins over a software clear.
    function automatic logic [CTD_STAT_W-1:0] w1c(input logic [CTD_STAT_W-1:0] cur,
                                                  input logic [CTD_STAT_W-1:0] set,
                                                  input logic [CTD_STAT_W-1:0] clr);
        w1c = (cur & ~clr) | set;
    endfunction

    ctd_evt_t              evt_q;       // Event routing control.
    ctd_evt_t              evt_d;
    logic [7:0]            dbg_q;       // Debug behaviour control.
    logic [7:0]            dbg_d;
    logic [15:0]           oflt_q;      // Fault values in the high byte, enables low.
    logic [15:0]           oflt_d;
    logic                  en_q;        // Timer enable.
    logic                  en_d;
    logic [CTD_STAT_W-1:0] stat_q;      // Sticky status.
    logic [CTD_STAT_W-1:0] stat_d;
    logic [CTD_STAT_W-1:0] mask_q;      // Interrupt mask.
    logic [CTD_STAT_W-1:0] mask_d;
    logic [31:0]           rdata_q;     // Read data, valid one cycle after the strobe.
    logic [31:0]           rdata_d;
    logic                  swrst;       // Software reset request this cycle.
    logic                  wr_ctrl;     // Decoded writes.
    logic                  wr_dbg;
    logic                  wr_evt;
    logic                  wr_oflt;
    logic                  wr_stat;
    logic                  wr_mask;
    logic [CTD_STAT_W-1:0] stat_set;    // Hardware events into the status register.
    logic                  cyc_occur;   // Selected counter cycle point.
    logic                  dbg_fault;   // Break request that raises a fault.
    logic [CTD_ACT_N-1:0]  act0_w;      // Action requests of the two inputs.
    logic [CTD_ACT_N-1:0]  act1_w;
    logic                  flt_now;     // Fault state seen by the output stage.

    // Address decode; writes to the guarded registers are blocked by the guard pin.
    always_comb begin
        wr_ctrl = 1'b0;
        wr_dbg  = 1'b0;
        wr_evt  = 1'b0;
        wr_oflt = 1'b0;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        if (!bus_req.wr) begin
            wr_ctrl = 1'b0;
        end else if (bus_req.addr == baddr(CTD_IDX_CTRL)) begin
            wr_ctrl = 1'b1;
        end else if (bus_req.addr == baddr(CTD_IDX_DBG)) begin
            wr_dbg = !write_guard;
        end else if (bus_req.addr == baddr(CTD_IDX_EVT)) begin
            wr_evt = !write_guard && !en_q;
        end else if (bus_req.addr == baddr(CTD_IDX_OFLT)) begin
            wr_oflt = !write_guard && !en_q;
        end else if (bus_req.addr == baddr(CTD_IDX_STAT)) begin
            wr_stat = 1'b1;
        end else if (bus_req.addr == baddr(CTD_IDX_MASK)) begin
            wr_mask = 1'b1;
        end
    end

    assign swrst = wr_ctrl && bus_req.wdata[CTD_CTRL_SWRST_BIT];

    // Counter cycle point selection.
    always_comb begin
        case (evt_q.cyc_sel)
            CTD_CYC_BEGIN:   cyc_occur = core_ev.cyc_begin;
            CTD_CYC_END:     cyc_occur = core_ev.cyc_end;
            CTD_CYC_BETWEEN: cyc_occur = core_ev.cyc_between;
            default:         cyc_occur = core_ev.cyc_first_begin | core_ev.cyc_last_end;
        endcase
    end

    // A break only faults when the enable bit is set.
    assign dbg_fault = dbg_break && dbg_q[CTD_DBG_FLT_BIT];

    // Status events; fault codes on either input raise a fault that holds until software clears its status bit.
    always_comb begin
        stat_set                    = '0;
        stat_set[CTD_STAT_DBGF_BIT] = dbg_fault;
        stat_set[CTD_STAT_F0_BIT]   = act0_w[CTD_ACT_FAULT];
        stat_set[CTD_STAT_F1_BIT]   = act1_w[CTD_ACT_FAULT];
        stat_set[CTD_STAT_CYC_BIT]  = cyc_occur;
    end

    // Next register values; software reset spares the debug register.
    always_comb begin
        evt_d   = evt_q;
        dbg_d   = dbg_q;
        oflt_d  = oflt_q;
        en_d    = en_q;
        mask_d  = mask_q;
        stat_d  = w1c(stat_q, stat_set, wr_stat ? bus_req.wdata[CTD_STAT_W-1:0] : '0);
        rdata_d = '0;
        if (swrst) begin
            evt_d  = CTD_EVT_RST;
            oflt_d = CTD_OFLT_RST;
            en_d   = 1'b0;
            mask_d = '0;
            stat_d = stat_set;
        end else begin
            if (wr_ctrl) begin
                en_d = bus_req.wdata[CTD_CTRL_EN_BIT];
            end
            if (wr_evt) begin
                evt_d         = ctd_evt_t'(bus_req.wdata);
                evt_d.rsv_hi  = '0;
                evt_d.rsv_mid = '0;
                evt_d.rsv_b11 = 1'b0;
            end
            if (wr_oflt) begin
                oflt_d = bus_req.wdata[15:0];
            end
            if (wr_mask) begin
                mask_d = bus_req.wdata[CTD_STAT_W-1:0];
            end
        end
        if (wr_dbg) begin
            dbg_d                  = '0;
            dbg_d[CTD_DBG_RUN_BIT] = bus_req.wdata[CTD_DBG_RUN_BIT];
            dbg_d[CTD_DBG_FLT_BIT] = bus_req.wdata[CTD_DBG_FLT_BIT];
        end
        // Read mux; unmapped addresses read zero.
        if (!bus_req.rd) begin
            rdata_d = '0;
        end else if (bus_req.addr == baddr(CTD_IDX_CTRL)) begin
            rdata_d[CTD_CTRL_EN_BIT] = en_q;
        end else if (bus_req.addr == baddr(CTD_IDX_DBG)) begin
            rdata_d[7:0] = dbg_q;
        end else if (bus_req.addr == baddr(CTD_IDX_EVT)) begin
            rdata_d = evt_q;
        end else if (bus_req.addr == baddr(CTD_IDX_OFLT)) begin
            rdata_d[15:0] = oflt_q;
        end else if (bus_req.addr == baddr(CTD_IDX_STAT)) begin
            rdata_d[CTD_STAT_W-1:0] = stat_q;
        end else if (bus_req.addr == baddr(CTD_IDX_MASK)) begin
            rdata_d[CTD_STAT_W-1:0] = mask_q;
        end
    end

    // Register state; only the hardware reset clears the debug register.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            evt_q   <= CTD_EVT_RST;
            dbg_q   <= CTD_DBG_RST;
            oflt_q  <= CTD_OFLT_RST;
            en_q    <= 1'b0;
            stat_q  <= '0;
            mask_q  <= '0;
            rdata_q <= '0;
        end else begin
            evt_q   <= evt_d;
            dbg_q   <= dbg_d;
            oflt_q  <= oflt_d;
            en_q    <= en_d;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            rdata_q <= rdata_d;
        end
    end

    // The fault holds until every fault status bit is cleared by software.
    assign flt_now = |stat_d[CTD_STAT_F1_BIT:CTD_STAT_DBGF_BIT];

    logic [CTD_OUT_N-1:0] wo_d;       // Next output levels.
    logic [CTD_OUT_N-1:0] wo_q;
    logic [CTD_OUT_N-1:0] oe_n_d;     // Next output enables, low while driving.
    logic [CTD_OUT_N-1:0] oe_n_q;
    logic                 run_d;      // Timer runs this cycle.
    logic                 run_q;
    logic                 flt_q;      // Registered fault state.
    logic [CTD_CH_N-1:0]  acc_d;      // Accepted channel input events.
    logic [CTD_CH_N-1:0]  acc_q;
    logic                 irq_q;      // Interrupt level.

    // Output override under fault; outputs without override float.
    always_comb begin
        wo_d   = wave_in;
        oe_n_d = '0;
        if (flt_now) begin
            wo_d   = oflt_q[15:8] & oflt_q[7:0];
            oe_n_d = ~oflt_q[7:0];
        end
    end

    // Run control and channel input acceptance.
    always_comb begin
        run_d = en_q && !(dbg_halt && !dbg_q[CTD_DBG_RUN_BIT]);
        acc_d = ch_ev_in & evt_q.ch_in_en;
    end

    // The output stage registers everything so no output is combinational.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wo_q   <= '0;
            oe_n_q <= '1;
            run_q  <= 1'b0;
            flt_q  <= 1'b0;
            acc_q  <= '0;
            irq_q  <= 1'b0;
        end else begin
            wo_q   <= wo_d;
            oe_n_q <= oe_n_d;
            run_q  <= run_d;
            flt_q  <= flt_now;
            acc_q  <= acc_d;
            irq_q  <= |(stat_d & mask_d);
        end
    end

    // Counter event inputs; input one sits in the high bits of each field.
    ctd_evt_in u_in0 (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .ev_in     (cnt_ev_in0),
        .en        (evt_q.in_en[0]),
        .inv       (evt_q.inv[0]),
        .act       (evt_q.act0),
        .act_pulse (act0_w)
    );

    ctd_evt_in u_in1 (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .ev_in     (cnt_ev_in1),
        .en        (evt_q.in_en[1]),
        .inv       (evt_q.inv[1]),
        .act       (evt_q.act1),
        .act_pulse (act1_w)
    );

    // Output events: channels, cycle, retrigger and wrap in one gated stage.
    logic [CTD_CH_N+2:0] oev_pulse;   // Registered output event pulses.

    ctd_evt_out #(
        .W (CTD_CH_N + 3)
    ) u_out (
        .sys_clk (sys_clk),
        .srst    (srst),
        .occur   ({core_ev.ch_match, cyc_occur, core_ev.retrig, core_ev.wrap}),
        .en      ({evt_q.ch_out_en, evt_q.cyc_eo, evt_q.trg_eo, evt_q.wrap_eo}),
        .pulse   (oev_pulse)
    );

    assign bus_rdata    = rdata_q;
    assign wave_out     = wo_q;
    assign wave_oe_n    = oe_n_q;
    assign timer_run    = run_q;
    assign fault_active = flt_q;
    assign ch_ev_accept = acc_q;
    assign ch_ev_out    = oev_pulse[CTD_CH_N+2:3];
    assign cyc_ev_out   = oev_pulse[2];
    assign trg_ev_out   = oev_pulse[1];
    assign wrap_ev_out  = oev_pulse[0];
    assign act0_pulse   = act0_w;
    assign act1_pulse   = act1_w;
    assign irq          = irq_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    chk_fault_float: assert property (flt_now && !oflt_q[0] |=> wave_oe_n[0])
        else $error("Output without override not floated under fault.");
    chk_fault_value: assert property (flt_now && oflt_q[8] && oflt_q[0] |=> !wave_oe_n[0] && wave_out[0])
        else $error("Overridden output not driven to fault value.");
    chk_dbg_keep: assert property (swrst && !wr_dbg |=> dbg_q == $past(dbg_q))
        else $error("Debug bits changed by software reset.");
    // The flag and the fault state are registered at the same edge, so both show one cycle after the break.
    chk_break_flag: assert property (
        dbg_break && dbg_q[CTD_DBG_FLT_BIT] |=> stat_q[CTD_STAT_DBGF_BIT] && fault_active)
        else $error("Debug break did not raise the fault.");
    chk_break_off: assert property (
        dbg_break && !dbg_q[CTD_DBG_FLT_BIT] && !stat_q[CTD_STAT_DBGF_BIT] |=> !stat_q[CTD_STAT_DBGF_BIT])
        else $error("Fault raised with break fault disabled.");
    chk_halt_stop: assert property (dbg_halt && !dbg_q[CTD_DBG_RUN_BIT] |=> !timer_run)
        else $error("Timer kept running during debug halt.");
    chk_ch_event: assert property (core_ev.ch_match[0] |=> ch_ev_out[0] == $past(evt_q.ch_out_en[0]))
        else $error("Channel event output wrong.");
    chk_ch_accept: assert property (ch_ev_accept[1] |-> $past(evt_q.ch_in_en[1]))
        else $error("Channel input event accepted while disabled.");
    chk_input_off: assert property (!evt_q.in_en[1] |=> act1_pulse == '0)
        else $error("Disabled counter input produced an action.");
    chk_cyc_begin: assert property (
        evt_q.cyc_sel == CTD_CYC_BEGIN && evt_q.cyc_eo && core_ev.cyc_begin |=> cyc_ev_out)
        else $error("Cycle event missing at cycle begin.");
    chk_pulse_len: assert property (wrap_ev_out && !$past(core_ev.wrap, 1) |-> 0)
        else $error("Wrap event without an occurrence.");
    chk_evt_locked: assert property (
        en_q && bus_req.wr && bus_req.addr == baddr(CTD_IDX_EVT) |=> $stable(evt_q))
        else $error("Event control changed while timer enabled.");
    chk_input_fault: assert property (act0_pulse[CTD_ACT_FAULT] |=> stat_q[CTD_STAT_F0_BIT])
        else $error("Input fault action did not set fault status.");

    cov_break_fault: cover property (dbg_break && dbg_q[CTD_DBG_FLT_BIT] ##2 fault_active);
    cov_retrigger:   cover property (act1_pulse[1] ##1 trg_ev_out);
    cov_boundary:    cover property (evt_q.cyc_sel == CTD_CYC_BOUNDARY && cyc_ev_out);
    cov_irq:         cover property (irq ##[1:4] !irq);

endmodule

// >>> core/ctd_pkg.sv
package ctd_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] CTD_IDX_CTRL  = 8'h00;   // Enable and software reset.
    localparam logic [7:0] CTD_IDX_OFLT  = 8'h18;   // Per-output fault override control.
    localparam logic [7:0] CTD_IDX_DBG   = 8'h1E;   // Debug behaviour control.
    localparam logic [7:0] CTD_IDX_EVT   = 8'h20;   // Event routing control.
    localparam logic [7:0] CTD_IDX_STAT  = 8'h2C;   // Sticky event status.
    localparam logic [7:0] CTD_IDX_MASK  = 8'h2D;   // Interrupt mask.

    // Field positions.
    localparam int CTD_CTRL_EN_BIT    = 0;          // Timer enable.
    localparam int CTD_CTRL_SWRST_BIT = 1;          // Software reset, self clearing.
    localparam int CTD_DBG_RUN_BIT    = 0;          // Run during debug halt.
    localparam int CTD_DBG_FLT_BIT    = 2;          // Debug break fault enable.
    localparam int CTD_STAT_DBGF_BIT  = 0;          // Debug fault flag.
    localparam int CTD_STAT_F0_BIT    = 1;          // Fault raised by input zero.
    localparam int CTD_STAT_F1_BIT    = 2;          // Fault raised by input one.
    localparam int CTD_STAT_CYC_BIT   = 3;          // Counter cycle event seen.
    localparam int CTD_STAT_W         = 4;          // Implemented status bits.
    localparam int CTD_OUT_N          = 8;          // Waveform outputs.
    localparam int CTD_CH_N           = 4;          // Compare/capture channels.

    // Reset values.
    localparam logic [31:0] CTD_EVT_RST  = 32'h0000_0000;
    localparam logic [7:0]  CTD_DBG_RST  = 8'h00;
    localparam logic [15:0] CTD_OFLT_RST = 16'h0000;

    // Cycle point select codes.
    localparam logic [1:0] CTD_CYC_BEGIN    = 2'h0;
    localparam logic [1:0] CTD_CYC_END      = 2'h1;
    localparam logic [1:0] CTD_CYC_BETWEEN  = 2'h2;
    localparam logic [1:0] CTD_CYC_BOUNDARY = 2'h3;

    // Action codes; input zero and input one share the code 0x7 for fault.
    localparam logic [2:0] CTD_ACT_OFF   = 3'h0;
    localparam logic [2:0] CTD_ACT_FAULT = 3'h7;
    localparam int         CTD_ACT_N     = 8;

    // Event routing control layout, most significant field first.
    typedef struct packed {
        logic [3:0] rsv_hi;      // Reads as zero.
        logic [3:0] ch_out_en;   // Channel event output enables.
        logic [3:0] rsv_mid;     // Reads as zero.
        logic [3:0] ch_in_en;    // Channel event input enables.
        logic [1:0] in_en;       // Counter event input enables, bit 1 is input one.
        logic [1:0] inv;         // Counter event input inversion.
        logic       rsv_b11;     // Reads as zero.
        logic       cyc_eo;      // Counter cycle event output enable.
        logic       trg_eo;      // Retrigger event output enable.
        logic       wrap_eo;     // Overflow/underflow event output enable.
        logic [1:0] cyc_sel;     // Cycle point select.
        logic [2:0] act1;        // Input one action.
        logic [2:0] act0;        // Input zero action.
    } ctd_evt_t;

    // Register bus request.
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ctd_bus_req_t;

    // Occurrences reported by the timer core, each a one-cycle pulse.
    typedef struct packed {
        logic [3:0] ch_match;
        logic       cyc_begin;
        logic       cyc_end;
        logic       cyc_between;
        logic       cyc_first_begin;
        logic       cyc_last_end;
        logic       retrig;
        logic       wrap;
    } ctd_core_ev_t;

endpackage

// >>> core/ctd_evt_in.sv
`timescale 1ns/10ps
module ctd_evt_in
    import ctd_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 srst,
    input  wire logic                 ev_in,
    input  wire logic                 en,
    input  wire logic                 inv,
    input  wire logic [2:0]           act,
    output logic      [CTD_ACT_N-1:0] act_pulse
);

    logic [CTD_ACT_N-1:0] act_d;   // One-hot action request.
    logic [CTD_ACT_N-1:0] act_q;   // Registered action request.
    logic                 src;     // Event source after optional inversion.

    // Inversion comes first, then the enable; code zero never yields a request.
    always_comb begin
        src   = ev_in ^ inv;
        act_d = '0;
        if (en && src && act != CTD_ACT_OFF) begin
            act_d[act] = 1'b1;
        end
    end

    // Registering gives the core a clean request that stays high as long as the source does.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            act_q <= '0;
        end else begin
            act_q <= act_d;
        end
    end

    assign act_pulse = act_q;

endmodule

// >>> core/ctd_evt_out.sv
`timescale 1ns/10ps
module ctd_evt_out
    import ctd_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] occur,
    input  wire logic [W-1:0] en,
    output logic      [W-1:0] pulse
);

    logic [W-1:0] pulse_d;   // Gated occurrence.
    logic [W-1:0] pulse_q;   // Pulse seen by the routing system.

    // Each occurrence is already one cycle long, so one pulse follows each.
    always_comb begin
        pulse_d = occur & en;
    end

    // Register so the routing system sees a glitch-free pulse.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pulse_q <= '0;
        end else begin
            pulse_q <= pulse_d;
        end
    end

    assign pulse = pulse_q;

endmodule

// >>> tb/ctd_evsys_model.sv
`timescale 1ns/10ps
// Event routing stand-in: it consumes every event the timer emits, counts cycle, retrigger and wrap events and notes which channels signalled.
module ctd_evsys_model
    import ctd_pkg::*;
(
    input wire logic                sys_clk,
    input wire logic [CTD_CH_N-1:0] ch_ev_out,
    input wire logic                cyc_ev_out,
    input wire logic                trg_ev_out,
    input wire logic                wrap_ev_out
);
    int                  cyc_n   = 0;   // Counter cycle events taken.
    int                  trg_n   = 0;   // Retrigger events taken.
    int                  wrap_n  = 0;   // Wrap events taken.
    logic [CTD_CH_N-1:0] ch_seen = '0;  // Channels that ever signalled.

    // Each high cycle is one event, so a stretched pulse shows up as extra counts.
    always @(posedge sys_clk) begin
        cyc_n   <= cyc_n + int'(cyc_ev_out);
        trg_n   <= trg_n + int'(trg_ev_out);
        wrap_n  <= wrap_n + int'(wrap_ev_out);
        ch_seen <= ch_seen | ch_ev_out;
    end
endmodule

// >>> tb/tb_ctd_top.sv
`timescale 1ns/10ps
module tb_ctd_top
    import ctd_pkg::*;
;
    logic         sys_clk = 1'b0;
    logic         srst = 1'b1;
    ctd_bus_req_t bus_req = '0;
    logic [31:0]  bus_rdata;
    logic         write_guard = 1'b0, dbg_halt = 1'b0, dbg_break = 1'b0;
    ctd_core_ev_t core_ev = '0;
    logic [3:0]   ch_ev_in = '0, ch_ev_accept, ch_ev_out;
    logic         in0 = 1'b0, in1 = 1'b0;
    logic [7:0]   wave_out, wave_oe_n, act0_pulse, act1_pulse;
    logic         timer_run, fault_active, cyc_ev_out, trg_ev_out, wrap_ev_out, irq;
    int           mismatches = 0, samples_checked = 0, prev;

    always #50 sys_clk = ~sys_clk;

    ctd_top dut (.sys_clk(sys_clk), .srst(srst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .write_guard(write_guard), .dbg_halt(dbg_halt), .dbg_break(dbg_break), .core_ev(core_ev),
        .ch_ev_in(ch_ev_in), .cnt_ev_in0(in0), .cnt_ev_in1(in1), .wave_in(8'h3C), .wave_out(wave_out),
        .wave_oe_n(wave_oe_n), .timer_run(timer_run), .fault_active(fault_active),
        .ch_ev_accept(ch_ev_accept), .ch_ev_out(ch_ev_out), .cyc_ev_out(cyc_ev_out),
        .trg_ev_out(trg_ev_out), .wrap_ev_out(wrap_ev_out), .act0_pulse(act0_pulse),
        .act1_pulse(act1_pulse), .irq(irq));

    ctd_evsys_model evs (.sys_clk(sys_clk), .ch_ev_out(ch_ev_out), .cyc_ev_out(cyc_ev_out),
        .trg_ev_out(trg_ev_out), .wrap_ev_out(wrap_ev_out));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Bus write: one strobe cycle, taken at the following edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk) bus_req.wr <= 1'b0;
    endtask

    // Bus read: the data stand only in the cycle after the strobe.
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk) bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk) bus_req.rd <= 1'b0;
        #1 chk(nm, exp, bus_rdata);
    endtask

    // Drives one cycle of core occurrences, then lets the pulse drain.
    task automatic occur(input ctd_core_ev_t v);
        @(posedge sys_clk) core_ev <= v;
        @(posedge sys_clk) core_ev <= '0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // A hung sequence counts as a failure.
    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        rd("evt", 8'h80, 32'h0000_0000);
        rd("dbg", 8'h78, 32'h0000_0000);
        // Without a fault the core levels pass through and every output is driven.
        chk("wave", 32'h3C, {24'h0, wave_out});
        chk("oe_n", 32'h0, {24'h0, wave_oe_n});
        // A break with the fault enable clear leaves the status empty.
        @(posedge sys_clk) dbg_break <= 1'b1;
        @(posedge sys_clk) dbg_break <= 1'b0;
        rd("stat", 8'hB0, 32'h0000_0000);
        wr(8'h80, 32'hFFFF_FFFF);
        rd("evt", 8'h80, 32'h0F0F_F7FF);
        wr(8'h80, 32'h0005_0100);
        @(posedge sys_clk) ch_ev_in <= 4'hF;
        @(posedge sys_clk) ch_ev_in <= 4'h0;
        #1 chk("accept", 32'h5, {28'h0, ch_ev_accept});
        occur('{retrig: 1'b1, wrap: 1'b1, default: 1'b0});
        chk("wrap", 32'd1, evs.wrap_n);
        chk("trg", 32'd0, evs.trg_n);
        // Every select code against every cycle point; only its own points count.
        for (int c = 0; c < 4; c++) begin
            wr(8'h80, 32'h0300_0600 | (c << 6));
            for (int k = 2; k < 7; k++) begin
                prev = evs.cyc_n;
                occur(ctd_core_ev_t'(11'h1 << k));
                chk("cyc", prev + int'((c == 3) ? (k <= 3) : (k == 6 - c)), evs.cyc_n);
            end
        end
        occur('{ch_match: 4'hF, retrig: 1'b1, default: 1'b0});
        chk("ch_out", 32'h3, {28'h0, evs.ch_seen});
        chk("trg", 32'd1, evs.trg_n);
        for (int c = 1; c < 7; c++) begin
            wr(8'h80, 32'h0000_C000 | (c << 3) | c);
            @(posedge sys_clk) {in0, in1} <= 2'b11;
            @(posedge sys_clk) {in0, in1} <= 2'b00;
            #1 chk("act0", 32'h1 << c, {24'h0, act0_pulse});
            chk("act1", 32'h1 << c, {24'h0, act1_pulse});
        end
        wr(8'h80, 32'h0000_F009);
        #201 chk("act0", 32'h2, {24'h0, act0_pulse});
        wr(8'h80, 32'h0000_3009);
        #201 chk("act1", 32'h0, {24'h0, act1_pulse});
        wr(8'h00, 32'h1);
        @(posedge sys_clk) dbg_halt <= 1'b1;
        #201 chk("run", 32'h0, {31'h0, timer_run});
        wr(8'h80, 32'h0);
        rd("evt", 8'h80, 32'h0000_3009);
        wr(8'h00, 32'h0);
        wr(8'h78, 32'h5);
        wr(8'h00, 32'h1);
        #201 chk("run", 32'h1, {31'h0, timer_run});
        wr(8'h00, 32'h2);
        write_guard <= 1'b1;
        wr(8'h78, 32'h0);
        write_guard <= 1'b0;
        rd("dbg", 8'h78, 32'h0000_0005);
        rd("evt", 8'h80, 32'h0000_0000);
        wr(8'h60, 32'h0000_A50F);
        wr(8'hB4, 32'h1);
        @(posedge sys_clk) dbg_break <= 1'b1;
        @(posedge sys_clk) dbg_break <= 1'b0;
        #301 chk("oe_n", 32'hF0, {24'h0, wave_oe_n});
        chk("wave", 32'h5, {28'h0, wave_out[3:0]});
        chk("fault", 32'h1, {31'h0, fault_active});
        chk("irq", 32'h1, {31'h0, irq});
        rd("stat", 8'hB0, 32'h0000_0001);
        wr(8'hB0, 32'h1);
        #301 chk("irq", 32'h0, {31'h0, irq});
        chk("fault", 32'h0, {31'h0, fault_active});
        report_and_stop();
    end
endmodule
